// *** core/led_matrix_consts.svh ***
// offsets, field positions, reset values and timing counts of the intensity/config block
// assumes inclusion by bare name from the block and the bench
`ifndef LED_MATRIX_CONSTS_SVH
`define LED_MATRIX_CONSTS_SVH

`define ADDR_DIGIT_ZERO    8'h03
`define ADDR_DIGIT_ONE     8'h04
`define ADDR_PANEL_SETUP   8'h0d

`define BIT_PLANE_MODE     7
`define BIT_COLOUR         6
`define BIT_MUX_FLIP       5
`define BIT_RIPPLE         4
`define BIT_PLANE_MSB      3
`define BIT_PLANE_LSB      2

`define RST_DIGIT          8'h00
`define RST_PANEL_SETUP    8'h00

`define CLK_PERIOD_PS      4000
// one period of internal_oscillator/4 between adjacent drivers
`define RIPPLE_DELAY_PS    953700
`define RIPPLE_CYCLES      ((`RIPPLE_DELAY_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// *** core/led_matrix_intensity_config.sv ***
// panel configuration, digit intensity pwm and frame modulation of the matrix driver
// assumes a register port decoded from the serial interface on clock_i, and a
// resync pin from the panel bus that arrives asynchronously
// How it works
// - bit 6 of 0x0d: 0 mono/rgb panel, 1 red-green-yellow panel
// - mono-only variants: colour bit reads zero, writes to it ignored
// - bit 7 of 0x0d: 0 four on/off planes, 1 two planes of 2-bit pixels
// - single-bit variants: plane-mode bit stays zero whatever is written
// - pixel 11 lit every frame, 00 never; arithmetic 10 is 1,0,1 and 01 is 0,1,0
// - geometric 10 lights even frames, 01 lights one in four from frame 1
// - register 0x03 holds digit 0 fraction n/256
// - register 0x04 holds digit 1 fraction n/256
// - digit on-time is n/256 of the panel pwm value
// - bits 3:2 report driving plane, read only
// - four-plane codes 00..11 are planes 0..3; two-plane codes 10,11 are 0,1
// - ripple sync delays each driver one oscillator/4 period per address step
// - mux flip reverses the pwm timing on alternate drivers
// - with flip, even addresses run normal timing, odd addresses flipped
`include "led_matrix_consts.svh"

module led_matrix_intensity_config #(
    parameter bit COLOUR_CAPABLE = 1'b1,
    parameter bit GREY_CAPABLE   = 1'b1
) (
    input  wire logic                        clock_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        reg_wr_i,
    input  wire logic [7:0]                  reg_addr_i,
    input  wire logic [7:0]                  reg_wdata_i,
    output logic      [7:0]                  reg_rdata_o,
    input  wire logic [7:0]                  driver_addr_i,
    input  wire logic [7:0]                  panel_pwm_i,
    input  wire logic [1:0]                  plane_sel_i,
    input  wire logic [1:0]                  graduation_geo_i,
    input  wire led_matrix_pkg::pixel_pair_s pixel_i,
    input  wire logic                        resync_pin_i,
    output logic      [1:0]                  led_on_o,
    output led_matrix_pkg::panel_cfg_s       cfg_o
);

    led_matrix_pkg::panel_cfg_s cfg_r;
    logic [1:0]                 low_bits_r;
    logic [7:0]                 digit0_r;
    logic [7:0]                 digit1_r;
    logic [7:0]                 rdata_r;
    logic                       sync_meta_r;
    logic                       sync_r;
    logic                       sync_d_r;
    logic                       sync_rise;
    led_matrix_pkg::mux_state_e state_r;
    logic [7:0]                 steps_left_r;
    logic [7:0]                 tick_r;
    logic [7:0]                 phase_r;
    logic                       digit_sel_r;
    logic [1:0]                 mod3_r;
    logic [1:0]                 mod4_r;
    logic [1:0]                 led_on_r;
    logic [1:0]                 plane_code;
    logic                       flipped;
    logic                       wr_panel;

    assign wr_panel  = reg_wr_i && (reg_addr_i == `ADDR_PANEL_SETUP);
    assign sync_rise = sync_r && !sync_d_r;
    assign flipped   = cfg_r.mux_flip && driver_addr_i[0];

    // two-plane mode reports planes 0 and 1 with the upper code bit set
    assign plane_code = cfg_r.plane_mode_select ? {1'b1, plane_sel_i[0]} : plane_sel_i;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cfg_r      <= '0;
            low_bits_r <= 2'h0;
        end else if (wr_panel) begin
            cfg_r.plane_mode_select <= GREY_CAPABLE && reg_wdata_i[`BIT_PLANE_MODE];
            cfg_r.colour_rgy        <= COLOUR_CAPABLE && reg_wdata_i[`BIT_COLOUR];
            cfg_r.mux_flip          <= reg_wdata_i[`BIT_MUX_FLIP];
            cfg_r.ripple_sync       <= reg_wdata_i[`BIT_RIPPLE];
            low_bits_r              <= reg_wdata_i[1:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            digit0_r <= `RST_DIGIT;
            digit1_r <= `RST_DIGIT;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `ADDR_DIGIT_ZERO) begin
                digit0_r <= reg_wdata_i;
            end
            if (reg_addr_i == `ADDR_DIGIT_ONE) begin
                digit1_r <= reg_wdata_i;
            end
        end
    end

    // plane bits come from live state, so a write never reaches them
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_r <= 8'h00;
        end else begin
            case (reg_addr_i)
                `ADDR_DIGIT_ZERO:  rdata_r <= digit0_r;
                `ADDR_DIGIT_ONE:   rdata_r <= digit1_r;
                `ADDR_PANEL_SETUP: rdata_r <= {cfg_r, plane_code, low_bits_r};
                default:           rdata_r <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sync_meta_r <= 1'b0;
            sync_r      <= 1'b0;
            sync_d_r    <= 1'b0;
        end else begin
            sync_meta_r <= resync_pin_i;
            sync_r      <= sync_meta_r;
            sync_d_r    <= sync_r;
        end
    end

    // each address step costs one oscillator/4 period before the mux starts
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_r      <= led_matrix_pkg::ST_IDLE;
            steps_left_r <= 8'h00;
            tick_r       <= 8'h00;
        end else begin
            case (state_r)
                led_matrix_pkg::ST_IDLE, led_matrix_pkg::ST_RUN: begin
                    if (sync_rise) begin
                        state_r      <= led_matrix_pkg::ST_WAIT;
                        steps_left_r <= cfg_r.ripple_sync ? driver_addr_i : 8'h00;
                        tick_r       <= 8'h00;
                    end
                end
                led_matrix_pkg::ST_WAIT: begin
                    if (steps_left_r == 8'h00) begin
                        state_r <= led_matrix_pkg::ST_RUN;
                    end else if (tick_r == 8'(`RIPPLE_CYCLES - 1)) begin
                        tick_r       <= 8'h00;
                        steps_left_r <= steps_left_r - 8'h01;
                    end else begin
                        tick_r <= tick_r + 8'h01;
                    end
                end
                default: state_r <= led_matrix_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i || state_r != led_matrix_pkg::ST_RUN) begin
            phase_r     <= 8'h00;
            digit_sel_r <= 1'b0;
            mod3_r      <= 2'h0;
            mod4_r      <= 2'h0;
        end else begin
            phase_r <= phase_r + 8'h01;
            if (phase_r == 8'hff) begin
                digit_sel_r <= !digit_sel_r;
                if (digit_sel_r) begin
                    mod3_r <= (mod3_r == 2'h2) ? 2'h0 : mod3_r + 2'h1;
                    mod4_r <= mod4_r + 2'h1;
                end
            end
        end
    end

    function automatic logic pixel_lit(input logic [1:0] v, input logic geo,
                                       input logic [1:0] m3, input logic [1:0] m4,
                                       input logic grey);
        logic lit;
        lit = 1'b0;
        if (!grey) begin
            lit = v[0];
        end else begin
            case (v)
                2'b11:   lit = 1'b1;
                2'b10:   lit = geo ? !m4[0] : (m3 != 2'h1);
                2'b01:   lit = geo ? (m4 == 2'h1) : (m3 == 2'h1);
                default: lit = 1'b0;
            endcase
        end
        return lit;
    endfunction : pixel_lit

    // with mux flip set, odd drivers place the on-time at the end of the digit slot
    function automatic logic pwm_on(input logic [7:0] n, input logic [7:0] panel,
                                    input logic [7:0] phase, input logic flip);
        logic [15:0] prod;
        logic [8:0]  on_time;
        prod    = 16'(n) * 16'(panel);
        on_time = {1'b0, prod[15:8]};
        return flip ? ({1'b0, phase} >= (9'h100 - on_time)) : ({1'b0, phase} < on_time);
    endfunction : pwm_on

    for (genvar d = 0; d < 2; d++) begin : g_digit
        logic [7:0] n;
        logic [1:0] pix;
        assign n   = (d == 0) ? digit0_r : digit1_r;
        assign pix = (d == 0) ? pixel_i.digit_zero : pixel_i.digit_one;
        always_ff @(posedge clock_i) begin
            if (!rst_n_i) begin
                led_on_r[d] <= 1'b0;
            end else begin
                led_on_r[d] <= (state_r == led_matrix_pkg::ST_RUN) && (digit_sel_r == 1'(d))
                               && pwm_on(n, panel_pwm_i, phase_r, flipped)
                               && pixel_lit(pix, graduation_geo_i[d], mod3_r, mod4_r,
                                            cfg_r.plane_mode_select);
            end
        end
    end

    assign reg_rdata_o = rdata_r;
    assign led_on_o    = led_on_r;
    assign cfg_o       = cfg_r;

    colour_fixed_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !COLOUR_CAPABLE |-> !cfg_r.colour_rgy) else $error("colour bit set on mono part");
    plane_fixed_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !GREY_CAPABLE |-> !cfg_r.plane_mode_select) else $error("plane mode set");
    colour_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wr_panel && COLOUR_CAPABLE |=> cfg_r.colour_rgy == $past(reg_wdata_i[`BIT_COLOUR]))
        else $error("colour bit not stored");
    plane_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wr_panel && GREY_CAPABLE
        |=> cfg_r.plane_mode_select == $past(reg_wdata_i[`BIT_PLANE_MODE]))
        else $error("plane mode not stored");
    digit_zero_store_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == `ADDR_DIGIT_ZERO |=> digit0_r == $past(reg_wdata_i))
        else $error("digit 0 value lost");
    digit_one_store_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == `ADDR_DIGIT_ONE |=> digit1_r == $past(reg_wdata_i))
        else $error("digit 1 value lost");
    plane_code_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        reg_addr_i == `ADDR_PANEL_SETUP && cfg_r.plane_mode_select |=> reg_rdata_o[3])
        else $error("two-plane code wrong");
    zero_digit_dark_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        digit0_r == 8'h00 |=> !led_on_o[0]) else $error("digit lit at zero");
    dark_pixel_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        pixel_i.digit_zero == 2'b00 |=> !led_on_o[0]) else $error("off pixel lit");
    flip_start_dark_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        flipped && phase_r == 8'h00 |=> led_on_o == 2'b00)
        else $error("flipped slot lit at start");
    ripple_delay_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        sync_rise && state_r != led_matrix_pkg::ST_WAIT && cfg_r.ripple_sync
        && driver_addr_i == 8'h01 |-> ##[240:242] state_r == led_matrix_pkg::ST_RUN)
        else $error("ripple delay wrong");

endmodule : led_matrix_intensity_config

// *** core/led_matrix_pkg.sv ***
// types shared by the intensity/config block
// assumes nothing beyond the constants header
package led_matrix_pkg;

    typedef struct packed {
        logic plane_mode_select;
        logic colour_rgy;
        logic mux_flip;
        logic ripple_sync;
    } panel_cfg_s;

    typedef struct packed {
        logic [1:0] digit_one;
        logic [1:0] digit_zero;
    } pixel_pair_s;

    typedef enum {
        ST_IDLE,
        ST_WAIT,
        ST_RUN
    } mux_state_e;

endpackage : led_matrix_pkg

// *** verif/host_model.sv ***
// host model: writes and reads registers over the decoded register port
// assumes read data is registered one cycle after the address
module host_model (
    input  wire logic       clock_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic            reg_wr_o,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_wr_o    = 1'b0;
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
    end
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_wr_o    <= 1'b1;
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        @(posedge clock_i);
        reg_wr_o    <= 1'b0;
        // released data is inverted so a stale value is never mistaken for a write
        reg_wdata_o <= ~d;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_addr_o <= a;
        @(posedge clock_i);
        @(negedge clock_i);
        d = reg_rdata_i;
    endtask : read_reg
endmodule : host_model

// *** verif/tb_top.sv ***
// bench for the intensity/config block: register map, frame patterns, pwm placement
// assumes host_model drives the register port; display-side inputs come from here
`include "led_matrix_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                        clock_i     = 1'b0;
    logic                        rst_n_i     = 1'b0;
    logic                        reg_wr;
    logic                  [7:0] reg_addr, reg_wdata, rdata, rdata_mono, d;
    logic                  [7:0] driver_addr = 8'h00;
    logic                  [7:0] panel_pwm   = 8'h80;
    logic                  [1:0] plane_sel   = 2'b00;
    logic                  [1:0] geo         = 2'b10;
    logic                        resync      = 1'b0;
    logic                  [1:0] led_on;
    led_matrix_pkg::pixel_pair_s pixel       = '0;
    led_matrix_pkg::panel_cfg_s  cfg, cfg_mono;
    logic                 [11:0] lit0, lit1;
    int                          fails = 0, num_checks = 0, cycles = 0;
    int                          cnt0, cnt1, first0, base;
    logic                  [7:0] ra [4] = '{8'h03, 8'h04, 8'h0d, 8'h05};
    logic                  [7:0] wa [4] = '{8'h03, 8'h03, 8'h04, 8'h04};
    logic                  [7:0] wv [4] = '{8'hff, 8'h80, 8'hff, 8'h40};

    always #2 clock_i = ~clock_i;

    host_model host_model_i (.clock_i(clock_i), .reg_rdata_i(rdata), .reg_wr_o(reg_wr),
        .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));
    led_matrix_intensity_config led_matrix_intensity_config_i (.clock_i(clock_i),
        .rst_n_i(rst_n_i), .reg_wr_i(reg_wr), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(rdata), .driver_addr_i(driver_addr), .panel_pwm_i(panel_pwm),
        .plane_sel_i(plane_sel), .graduation_geo_i(geo), .pixel_i(pixel),
        .resync_pin_i(resync), .led_on_o(led_on), .cfg_o(cfg));
    // mono, single-bit variant shares every input
    led_matrix_intensity_config #(.COLOUR_CAPABLE(1'b0), .GREY_CAPABLE(1'b0))
        led_matrix_intensity_config_mono_i (.clock_i(clock_i),
        .rst_n_i(rst_n_i), .reg_wr_i(reg_wr), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(rdata_mono), .driver_addr_i(driver_addr), .panel_pwm_i(panel_pwm),
        .plane_sel_i(plane_sel), .graduation_geo_i(geo), .pixel_i(pixel),
        .resync_pin_i(resync), .led_on_o(), .cfg_o(cfg_mono));

    function automatic logic [11:0] pattern(input logic g, input logic [1:0] v);
        case (v)
            2'b11: return 12'hfff;
            2'b10: return g ? 12'haaa : 12'hb6d;
            2'b01: return g ? 12'h444 : 12'h492;
            default: return 12'h000;
        endcase
    endfunction : pattern

    task automatic check_val(input string what, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", what, e, g);
        end
    endtask : check_val

    task automatic test_done;
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    // windows of 512 cycles from the resync edge; digit 1 windows lag by one slot
    task automatic run_frames;
        lit0 = '0;
        lit1 = '0;
        cnt0 = 0;
        cnt1 = 0;
        first0 = -1;
        @(posedge clock_i);
        resync <= 1'b1;
        for (int k = 0; k < 6400; k++) begin
            @(negedge clock_i);
            if (k < 6144 && led_on[0] !== 1'b0) begin
                lit0[11 - k / 512] = 1'b1;
                cnt0 = (k < 512) ? cnt0 + 1 : cnt0;
                first0 = (first0 < 0) ? k : first0;
            end
            if (k >= 256 && led_on[1] !== 1'b0) begin
                lit1[11 - (k - 256) / 512] = 1'b1;
                cnt1 = (k < 768) ? cnt1 + 1 : cnt1;
            end
        end
        @(posedge clock_i);
        resync <= 1'b0;
        repeat (4) @(posedge clock_i);
    endtask : run_frames

    // ceiling covers ten frame runs of 6400 cycles plus register traffic
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 75000) begin
            fails++;
            test_done();
        end
    end

    initial begin
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        foreach (ra[i]) begin
            host_model_i.read_reg(ra[i], d);
            check_val("reset value", 16'h0000, {8'h00, d});
        end
        foreach (wa[i]) begin
            host_model_i.write_reg(wa[i], wv[i]);
            host_model_i.read_reg(wa[i], d);
            check_val("digit brightness", {8'h00, wv[i]}, {8'h00, d});
        end
        @(posedge clock_i);
        plane_sel <= 2'd2;
        host_model_i.write_reg(8'h0d, 8'hff);
        host_model_i.read_reg(8'h0d, d);
        check_val("panel setup", 16'h00fb, {8'h00, d});
        check_val("mono panel setup", 16'h003b, {8'h00, rdata_mono});
        check_val("cfg", 16'h000f, {12'h000, cfg});
        check_val("mono cfg", 16'h0003, {12'h000, cfg_mono});
        @(posedge clock_i);
        plane_sel <= 2'd1;
        host_model_i.write_reg(8'h0d, 8'h0c);
        host_model_i.read_reg(8'h0d, d);
        check_val("plane code", 16'h0004, {8'h00, d});
        $display("register test done");
        @(posedge clock_i);
        pixel <= 4'b1001;
        host_model_i.write_reg(8'h0d, 8'h00);
        run_frames();
        check_val("single-bit lit", 16'h0fff, {4'h0, lit0});
        check_val("single-bit dark", 16'h0000, {4'h0, lit1});
        check_val("digit 0 on-time", 16'd64, 16'(cnt0));
        base = first0;
        host_model_i.write_reg(8'h0d, 8'h80);
        for (int v = 3; v >= 0; v--) begin
            @(posedge clock_i);
            pixel <= {v[1:0], v[1:0]};
            run_frames();
            check_val("arithmetic", {4'h0, pattern(1'b0, v[1:0])}, {4'h0, lit0});
            check_val("geometric", {4'h0, pattern(1'b1, v[1:0])}, {4'h0, lit1});
        end
        @(posedge clock_i);
        geo   <= 2'b01;
        pixel <= 4'b1110;
        run_frames();
        check_val("geometric half", 16'h0aaa, {4'h0, lit0});
        check_val("digit 1 on-time", 16'd32, 16'(cnt1));
        $display("pattern test done");
        @(posedge clock_i);
        geo         <= 2'b10;
        pixel       <= 4'b1111;
        driver_addr <= 8'h01;
        host_model_i.write_reg(8'h0d, 8'ha0);
        run_frames();
        check_val("flipped start", 16'(base + 192), 16'(first0));
        check_val("flipped on-time", 16'd64, 16'(cnt0));
        @(posedge clock_i);
        driver_addr <= 8'h02;
        run_frames();
        check_val("even start", 16'(base), 16'(first0));
        @(posedge clock_i);
        driver_addr <= 8'h01;
        host_model_i.write_reg(8'h0d, 8'h90);
        run_frames();
        check_val("ripple start", 16'(base + `RIPPLE_CYCLES), 16'(first0));
        host_model_i.write_reg(8'h03, 8'h00);
        run_frames();
        check_val("zero digit on-time", 16'd0, 16'(cnt0));
        $display("timing test done");
        test_done();
    end
endmodule : tb_top
